/* hdl/ifp_top.sv */
// AHB-Lite slave that assigns control functions to general input ports.
`timescale 1ns/1ns
`include "ifp_params.svh"
// Contract
// [RL1] Alarm clear select routes it to port 0-7.
// [RL2] Alarm clear invert flips its active level.
// [RL3] Motion stop select binds it to port.
// [RL4] Motion stop invert flips its active level.
// [RL5] Hold select binds port; invert flips it.
// [RL6] Resume select binds port; invert flips it.
// [RL7] Assignment clear cancels every function assignment.
// [RL8] Assignments live only in volatile flops.
// [RL9] Power-on restores factory default assignments.
// [RL10] Program launch restores factory default assignments.
// [RL11] Qualifying alarm clear restores factory defaults.
// [RL12] Host selects alarm clear port before invert.
// [RL13] Host selects motion stop port before invert.
// [RL14] Host selects hold/resume port before invert.
// [RL15] Port monitor shows raw inputs, no inversion.
// [RL16] Port selects are write-only, read zero.
// [RL17] Out-of-range select is rejected, map kept.
module ifp_top #(
	parameter int unsigned PORTS = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [PORTS-1:0] gpi,
	input wire logic start_input,
	input wire logic alarm_restorable,
	output logic alarm_clear_input,
	output logic motion_stop_input,
	output logic hold_input,
	output logic resume_input
);

	localparam int unsigned NF = ifp_pkg::IFP_NUM_FN;

	// True when a word address hits the given register offset.
	function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] off);
		reg_hit = (a[31:8] == 24'h00_0000) && (a[7:0] == off);
	endfunction

	// Offset of the select register for one function.
	function automatic logic [7:0] sel_off(input int unsigned f);
		case (f)
			0: sel_off = `IFP_OFF_SEL_ALARM;
			1: sel_off = `IFP_OFF_SEL_STOP;
			2: sel_off = `IFP_OFF_SEL_HOLD;
			default: sel_off = `IFP_OFF_SEL_RESUME;
		endcase
	endfunction

	// Factory default port for one function.
	function automatic ifp_pkg::ifp_port_t sel_def(input int unsigned f);
		case (f)
			0: sel_def = `IFP_DEF_SEL_ALARM;
			1: sel_def = `IFP_DEF_SEL_STOP;
			2: sel_def = `IFP_DEF_SEL_HOLD;
			default: sel_def = `IFP_DEF_SEL_RESUME;
		endcase
	endfunction

	logic addr_ph;
	logic wr_q;
	logic [31:0] addr_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_d;
	ifp_pkg::ifp_port_t sel_q [NF];
	logic [NF-1:0] inv_q;
	logic [NF-1:0] en_q;
	logic [NF-1:0] func;
	logic [NF-1:0] sel_wr;
	logic sel_ok;
	logic cmd_wr;
	logic inv_wr;
	logic io_clear;
	logic run_cmd;
	logic fault_cmd;
	logic reject_clr;
	logic reject_set;
	logic reject_q;
	logic start_q;
	logic alarm_q;
	logic start_rise;
	logic alarm_rise;
	logic restore;

	// The slave never stalls and never errors, so every transfer finishes in its first data-phase cycle.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign addr_ph = hsel & htrans[1] & hready;

	// Address phase capture for the write that follows in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			addr_q <= 32'h0000_0000;
		end else begin
			wr_q <= addr_ph & hwrite;
			if (addr_ph) begin
				addr_q <= haddr;
			end
		end
	end

	// Data-phase decode; hsize is not checked because only whole-word transfers are issued.
	always_comb begin
		for (int unsigned f = 0; f < NF; f++) begin
			sel_wr[f] = wr_q & reg_hit(addr_q, sel_off(f));
		end
	end
	assign sel_ok = (hwdata <= `IFP_PORT_MAX); // [RL17]
	assign cmd_wr = wr_q & reg_hit(addr_q, `IFP_OFF_CMD);
	assign inv_wr = wr_q & reg_hit(addr_q, `IFP_OFF_INV);
	assign io_clear = cmd_wr & hwdata[`IFP_CMD_IO_CLEAR];
	assign run_cmd = cmd_wr & hwdata[`IFP_CMD_RUN];
	assign fault_cmd = cmd_wr & hwdata[`IFP_CMD_FAULT_CLEAR];
	assign reject_clr = cmd_wr & hwdata[`IFP_CMD_REJECT_CLR];
	assign reject_set = (|sel_wr) & !sel_ok; // [RL17]

	// Edge detectors for the start pin and the routed alarm clear function.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_q <= 1'b0;
			alarm_q <= 1'b0;
		end else begin
			start_q <= start_input;
			alarm_q <= func[ifp_pkg::ifp_fn_alarm_clear];
		end
	end
	assign start_rise = start_input & !start_q;
	assign alarm_rise = func[ifp_pkg::ifp_fn_alarm_clear] & !alarm_q;

	// Launching a program, by command or by the start pin, always restores defaults.
	// An alarm clear restores them only when the pending alarm is one that qualifies.
	assign restore = run_cmd | start_rise // [RL10]
		| (alarm_restorable & (fault_cmd | alarm_rise)); // [RL11]

	// Port map: plain flops with no path to non-volatile storage, so power loss forgets it.
	// A restore outranks a select or clear written in the same cycle, so a launch always starts clean.
	always_ff @(posedge hclk or negedge hresetn) begin // [RL8]
		if (!hresetn) begin
			sel_q[0] <= `IFP_DEF_SEL_ALARM; // [RL9]
			sel_q[1] <= `IFP_DEF_SEL_STOP;
			sel_q[2] <= `IFP_DEF_SEL_HOLD;
			sel_q[3] <= `IFP_DEF_SEL_RESUME;
			en_q <= `IFP_DEF_EN; // [RL9]
		end else if (restore) begin
			for (int unsigned f = 0; f < NF; f++) begin
				sel_q[f] <= sel_def(f);
			end
			en_q <= `IFP_DEF_EN;
		end else begin
			for (int unsigned f = 0; f < NF; f++) begin
				if (sel_wr[f] && sel_ok) begin
					sel_q[f] <= hwdata[2:0]; // [RL1] [RL3] [RL5] [RL6]
				end
			end
			if (io_clear) begin
				en_q <= 4'h0; // [RL7]
			end else begin
				en_q <= en_q | (sel_wr & {NF{sel_ok}});
			end
		end
	end

	// Inversion flags share the restore path with the port map.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			inv_q <= `IFP_DEF_INV;
		end else if (restore) begin
			inv_q <= `IFP_DEF_INV;
		end else if (inv_wr) begin
			inv_q <= hwdata[NF-1:0]; // [RL2] [RL4] [RL5] [RL6]
		end
	end

	// Sticky reject flag; a new reject in the clearing cycle keeps it set.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reject_q <= 1'b0;
		end else begin
			reject_q <= reject_set | (reject_q & !reject_clr);
		end
	end

	// One router per function.
	for (genvar g = 0; g < NF; g++) begin : g_fn
		ifp_route #(
			.PORTS(PORTS)
		) u_route (
			.hclk(hclk),
			.hresetn(hresetn),
			.gpi(gpi),
			.sel(sel_q[g]),
			.inv(inv_q[g]),
			.en(en_q[g]),
			.func_q(func[g])
		);
	end
	assign alarm_clear_input = func[ifp_pkg::ifp_fn_alarm_clear];
	assign motion_stop_input = func[ifp_pkg::ifp_fn_motion_stop];
	assign hold_input = func[ifp_pkg::ifp_fn_hold];
	assign resume_input = func[ifp_pkg::ifp_fn_resume];

	// Read mux, evaluated in the address phase so the data phase sees a flop.
	// Select and command registers read as zero: the port selects are seen only through the functions.
	always_comb begin
		rd_d = 32'h0000_0000;
		if (reg_hit(haddr, `IFP_OFF_INV)) begin
			rd_d[NF-1:0] = inv_q;
		end else if (reg_hit(haddr, `IFP_OFF_MON)) begin
			rd_d[PORTS-1:0] = gpi; // [RL15]
		end else if (reg_hit(haddr, `IFP_OFF_STATUS)) begin
			rd_d[`IFP_ST_FUNC_LSB +: NF] = func;
			rd_d[`IFP_ST_EN_LSB +: NF] = en_q;
			rd_d[`IFP_ST_REJECT] = reject_q;
		end
	end

	// Read data register; unmapped and write-only offsets return zero with OKAY.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (addr_ph && !hwrite) begin
			hrdata_q <= rd_d; // [RL16]
		end
	end

	// Helper for the checks: the level each function should show one cycle later.
	logic [NF-1:0] exp_fn;
	always_comb begin
		for (int unsigned f = 0; f < NF; f++) begin
			exp_fn[f] = en_q[f] & (gpi[sel_q[f]] ^ inv_q[f]);
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Each check below guards one rule; its tag sits at the end of the label's line.
	a_alarm_select: assert property (sel_wr[0] && sel_ok && !restore |=> // [RL1]
		sel_q[0] == $past(hwdata[2:0]) && en_q[0])
		else $error("Alarm clear port select not taken.");

	a_stop_select: assert property (sel_wr[1] && sel_ok && !restore |=> // [RL3]
		sel_q[1] == $past(hwdata[2:0]) && en_q[1])
		else $error("Motion stop port select not taken.");

	a_hold_select: assert property (sel_wr[2] && sel_ok && !restore |=> // [RL5]
		sel_q[2] == $past(hwdata[2:0]))
		else $error("Hold port select not taken.");

	a_resume_select: assert property (sel_wr[3] && sel_ok && !restore |=> // [RL6]
		sel_q[3] == $past(hwdata[2:0]))
		else $error("Resume port select not taken.");

	a_alarm_invert: assert property ($past(hresetn) |-> // [RL2]
		alarm_clear_input == $past(exp_fn[0]))
		else $error("Alarm clear level does not follow port and invert.");

	a_stop_invert: assert property ($past(hresetn) |-> // [RL4]
		motion_stop_input == $past(exp_fn[1]))
		else $error("Motion stop level does not follow port and invert.");

	a_hold_invert: assert property ($past(hresetn) |-> // [RL5]
		hold_input == $past(exp_fn[2]))
		else $error("Hold level does not follow port and invert.");

	a_resume_invert: assert property ($past(hresetn) |-> // [RL6]
		resume_input == $past(exp_fn[3]))
		else $error("Resume level does not follow port and invert.");

	a_io_clear_all: assert property (io_clear && !restore |=> en_q == 4'h0 ##1 func == 4'h0) // [RL7]
		else $error("Assignment clear left a function assigned.");

	a_reject_keep: assert property ((|sel_wr) && !sel_ok && !restore |=> // [RL17]
		$stable(en_q) && sel_q[0] == $past(sel_q[0]) && sel_q[2] == $past(sel_q[2]) && reject_q)
		else $error("Out-of-range select changed the map.");

	a_reject_sticky: assert property (reject_q && !reject_clr |=> reject_q) // [RL17]
		else $error("Reject flag dropped without a clear.");

	// Reset values are the factory map, so a power cycle forgets any custom assignment.
	a_power_default: assert property (!$past(hresetn) |-> // [RL9]
		en_q == `IFP_DEF_EN && inv_q == `IFP_DEF_INV && sel_q[3] == `IFP_DEF_SEL_RESUME)
		else $error("Reset did not leave the factory map.");

	a_launch_default: assert property (start_input && !start_q |=> // [RL10]
		en_q == `IFP_DEF_EN && inv_q == `IFP_DEF_INV && sel_q[1] == `IFP_DEF_SEL_STOP)
		else $error("Program launch did not restore defaults.");

	a_run_default: assert property (run_cmd |=> // [RL10]
		sel_q[2] == `IFP_DEF_SEL_HOLD && sel_q[3] == `IFP_DEF_SEL_RESUME && en_q == `IFP_DEF_EN)
		else $error("Run command did not restore defaults.");

	a_restore_wins: assert property (restore |=> // [RL10]
		en_q == `IFP_DEF_EN && inv_q == `IFP_DEF_INV && sel_q[0] == `IFP_DEF_SEL_ALARM)
		else $error("A write in the restore cycle overrode the defaults.");

	a_alarm_default: assert property (alarm_restorable && fault_cmd |=> // [RL11]
		en_q == `IFP_DEF_EN && sel_q[0] == `IFP_DEF_SEL_ALARM)
		else $error("Alarm clear did not restore defaults.");

	a_alarm_pin_default: assert property (alarm_restorable && alarm_rise |=> // [RL11]
		en_q == `IFP_DEF_EN && inv_q == `IFP_DEF_INV)
		else $error("Alarm clear pin did not restore defaults.");

	a_alarm_keep: assert property (fault_cmd && !restore && !io_clear |=> // [RL11]
		$stable(inv_q) && $stable(en_q))
		else $error("Non-qualifying alarm clear changed the map.");

	a_monitor_raw: assert property (addr_ph && !hwrite && reg_hit(haddr, `IFP_OFF_MON) |=> // [RL15]
		hrdata[PORTS-1:0] == $past(gpi))
		else $error("Port monitor does not show raw inputs.");

	a_select_unread: assert property (addr_ph && !hwrite && reg_hit(haddr, `IFP_OFF_SEL_HOLD) |=> // [RL16]
		hrdata == 32'h0000_0000)
		else $error("Port select register read back non-zero.");

	a_alarm_unread: assert property (addr_ph && !hwrite && reg_hit(haddr, `IFP_OFF_SEL_ALARM) |=> // [RL16]
		hrdata == 32'h0000_0000)
		else $error("Alarm clear select register read back non-zero.");

	// The main scenarios the bench is meant to reach.
	c_select_then_invert: cover property (sel_wr[0] && sel_ok ##[1:8] inv_wr);
	c_restore_by_start: cover property (start_rise && en_q != `IFP_DEF_EN);
	c_alarm_pin_restore: cover property (alarm_rise && alarm_restorable);
	c_reject_seen: cover property (reject_set);
	c_io_clear_seen: cover property (io_clear);

endmodule

/* hdl/ifp_params.svh */
// Register offsets, field positions and reset defaults of the input function port assignment block.
`ifndef IFP_PARAMS_SVH
`define IFP_PARAMS_SVH

// Register byte offsets on the AHB-Lite bus.
`define IFP_OFF_CMD 8'h00
`define IFP_OFF_SEL_ALARM 8'h04
`define IFP_OFF_SEL_STOP 8'h08
`define IFP_OFF_SEL_HOLD 8'h0c
`define IFP_OFF_SEL_RESUME 8'h10
`define IFP_OFF_INV 8'h14
`define IFP_OFF_MON 8'h18
`define IFP_OFF_STATUS 8'h1c

// Command register bit positions.
`define IFP_CMD_IO_CLEAR 0
`define IFP_CMD_RUN 1
`define IFP_CMD_FAULT_CLEAR 2
`define IFP_CMD_REJECT_CLR 3

// Status register field positions.
`define IFP_ST_FUNC_LSB 0
`define IFP_ST_EN_LSB 4
`define IFP_ST_REJECT 8

// Highest accepted port index.
`define IFP_PORT_MAX 32'h0000_0007

// Factory defaults restored at power-on, program launch and qualifying alarm clear.
`define IFP_DEF_SEL_ALARM 3'h0
`define IFP_DEF_SEL_STOP 3'h1
`define IFP_DEF_SEL_HOLD 3'h2
`define IFP_DEF_SEL_RESUME 3'h3
`define IFP_DEF_INV 4'h0
`define IFP_DEF_EN 4'hf

`endif

/* hdl/ifp_pkg.sv */
// Types shared by the input function port assignment block.
package ifp_pkg;

	// One entry per routable control function, in status bit order.
	typedef enum {ifp_fn_alarm_clear, ifp_fn_motion_stop, ifp_fn_hold, ifp_fn_resume} ifp_fn_t;

	// Index of a general input port.
	typedef logic [2:0] ifp_port_t;

	// Number of routable functions.
	localparam int unsigned IFP_NUM_FN = 4;

endpackage

/* hdl/ifp_route.sv */
// One function router: picks a general input port, applies inversion and the assigned flag.
`timescale 1ns/1ns
module ifp_route #(
	parameter int unsigned PORTS = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [PORTS-1:0] gpi,
	input wire logic [$clog2(PORTS)-1:0] sel,
	input wire logic inv,
	input wire logic en,
	output logic func_q
);

	logic func_d;

	// An unassigned function reads inactive whatever its port does, so a cleared map stops nothing by accident.
	always_comb begin
		func_d = en & (gpi[sel] ^ inv);
	end

	// Registered so the function output is a clean flop, one cycle behind the port.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			func_q <= 1'b0;
		end else begin
			func_q <= func_d;
		end
	end

	a_route_unassigned: assert property (@(posedge hclk) disable iff (!hresetn)
		!en |=> !func_q)
		else $error("Unassigned function output is active.");

endmodule

/* sim/ifp_gpi_model.sv */
// Model of the field signals wired to the general input ports.
`timescale 1ns/1ns
module ifp_gpi_model (
	input wire logic hclk,
	input wire logic [7:0] level,
	output logic [7:0] gpi
);
	// The field changes only just after an edge, as a synchronised input would.
	initial gpi = 8'h00;
	always @(posedge hclk) begin
		gpi <= level;
	end
endmodule

/* sim/tb.sv */
// Self-checking bench for the input function port assignment block.
`timescale 1ns/1ns
`include "ifp_params.svh"
module tb;
	logic hclk, hresetn, hsel, hwrite, start_input, alarm_restorable, hreadyout, hresp;
	logic alm, mst, hld, rsm;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] lvl, gpi;
	logic [2:0] m_sel [4];
	logic [3:0] m_inv, m_en;
	int n_fail, n_compared, cyc;

	// Free-running bus clock.
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	ifp_gpi_model i_gpi (.hclk(hclk), .level(lvl), .gpi(gpi));
	ifp_top #(.PORTS(8)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .gpi, .start_input,
		.alarm_restorable, .alarm_clear_input(alm), .motion_stop_input(mst), .hold_input(hld),
		.resume_input(rsm));

	// Expected function levels, worked out from the bench's own copy of the map.
	function automatic logic [3:0] exp_fn(input logic [7:0] g);
		logic [3:0] r;
		for (int f = 0; f < 4; f++) r[f] = m_en[f] & (g[m_sel[f]] ^ m_inv[f]);
		return r;
	endfunction

	task automatic stop_test;
		$display("failures %0d, comparisons %0d", n_fail, n_compared);
		if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// One single transfer; the master never assumes the slave answers at once.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0, "response");
	endtask

	task automatic dflt;
		m_sel = '{`IFP_DEF_SEL_ALARM, `IFP_DEF_SEL_STOP, `IFP_DEF_SEL_HOLD, `IFP_DEF_SEL_RESUME};
		m_inv = `IFP_DEF_INV;
		m_en = `IFP_DEF_EN;
	endtask

	task automatic sw(input int f, input logic [31:0] p);
		bus(1'b1, `IFP_OFF_SEL_ALARM + 8'(4 * f), p);
		if (p <= `IFP_PORT_MAX) begin
			m_sel[f] = p[2:0];
			m_en[f] = 1'b1;
		end
	endtask

	task automatic inv(input logic [3:0] v);
		m_inv = v;
		bus(1'b1, `IFP_OFF_INV, {28'h0, v});
	endtask

	// Drive the field, let the map settle, then judge the pins and the status word.
	task automatic apply(input logic [7:0] g);
		lvl <= g;
		repeat (6) @(posedge hclk);
		#1 chk({28'h0, rsm, hld, mst, alm}, {28'h0, exp_fn(g)}, "function pins");
		bus(1'b0, `IFP_OFF_STATUS, 32'h0);
		chk({24'h0, rd[7:0]}, {24'h0, m_en, exp_fn(g)}, "status");
	endtask

	task automatic t_dflt;
		dflt();
		apply(8'h0f);
		apply(8'hf5);
	endtask

	// Every function moves to a high port, selected before its invert is set.
	task automatic t_route;
		for (int f = 0; f < 4; f++) begin
			sw(f, 7 - f);
			inv(m_inv | 4'(1 << f));
			apply(8'h80 >> f);
		end
		apply(8'h5a);
		bus(1'b0, `IFP_OFF_MON, 32'h0);
		chk(rd, 32'h5a, "raw monitor");
		bus(1'b0, `IFP_OFF_SEL_HOLD, 32'h0);
		chk(rd, 32'h0, "select read");
		bus(1'b0, `IFP_OFF_SEL_ALARM, 32'h0);
		chk(rd, 32'h0, "alarm select read");
		bus(1'b0, `IFP_OFF_INV, 32'h0);
		chk(rd, {28'h0, m_inv}, "invert read");
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0, "unmapped read");
	endtask

	task automatic t_rej;
		sw(2, 32'h8);
		apply(8'h08);
		chk({31'h0, rd[8]}, 32'h1, "reject flag");
		bus(1'b1, `IFP_OFF_CMD, 32'h8);
		bus(1'b0, `IFP_OFF_STATUS, 32'h0);
		chk({31'h0, rd[8]}, 32'h0, "reject cleared");
	endtask

	task automatic t_clr;
		bus(1'b1, `IFP_OFF_CMD, 32'h1);
		m_en = 4'h0;
		apply(8'hff);
		sw(1, 6);
		apply(8'h40);
	endtask

	// Custom map, then each restoring event; a non-qualifying alarm clear keeps it.
	task automatic t_rst;
		for (int m = 0; m < 5; m++) begin
			sw(0, 5);
			sw(2, 6);
			inv(4'h5);
			case (m)
				0: bus(1'b1, `IFP_OFF_CMD, 32'h2);
				1: begin
					start_input <= 1'b1;
					@(posedge hclk);
					start_input <= 1'b0;
				end
				2: begin
					// Dropped right after the command, so the next custom select cannot restore by the pin.
					alarm_restorable <= 1'b1;
					bus(1'b1, `IFP_OFF_CMD, 32'h4);
					alarm_restorable <= 1'b0;
				end
				3: begin
					alarm_restorable <= 1'b0;
					bus(1'b1, `IFP_OFF_CMD, 32'h4);
				end
				default: begin
					alarm_restorable <= 1'b1;
					@(posedge hclk);
				end
			endcase
			if (m != 3) dflt();
			apply((m == 4) ? 8'h00 : 8'h22);
		end
		alarm_restorable <= 1'b0;
	endtask

	// A reset in mid-run stands in for a power cycle: the custom map must not survive it.
	task automatic t_por;
		sw(3, 7);
		inv(4'ha);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		dflt();
		apply(8'h0a);
	endtask

	// A hang is cut short well above the expected run length.
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		{hresetn, hsel, hwrite, start_input, alarm_restorable} = 5'h0;
		{haddr, hwdata, htrans, lvl} = '0;
		hsize = 3'h2;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_dflt();
		t_route();
		t_rej();
		t_clr();
		t_rst();
		t_por();
		stop_test();
	end
endmodule
